// File: logic/bgs_defs.svh
// Offsets, field positions, reset values and timing counts of the bridge guard
`ifndef BGS_DEFS_SVH
`define BGS_DEFS_SVH

// ==========================================================
// Register map (byte addresses, one 32-bit word each)
`define BGS_ADDR_W        12
`define BGS_OFS_CTRL      12'h000
`define BGS_OFS_STATUS    12'h004
`define BGS_OFS_INT_STAT  12'h008
`define BGS_OFS_INT_MASK  12'h00C
`define BGS_CTRL_RESET    32'h0000_0000
`define BGS_MASK_RESET    4'h0

// ==========================================================
// Control field positions
`define BGS_F_LS_SLOPE    0
`define BGS_F_HS_SLOPE    2
`define BGS_F_DLY_SEL     4
`define BGS_F_HS_SENS     6
`define BGS_F_PROT_DIS    7
`define BGS_F_LS_DET_EN   8
`define BGS_F_OFF_TIME    9
`define BGS_CTRL_BITS     13

// ==========================================================
// Status field positions
`define BGS_S_FAULT       0
`define BGS_S_LS_FAULT    2
`define BGS_S_HS_FAULT    4
`define BGS_S_DISABLED    6
`define BGS_S_BRIDGE_OFF  7

// ==========================================================
// Interrupt bits: confirmed fault per coil, retry per coil
`define BGS_I_FAULT       0
`define BGS_I_RETRY       2
`define BGS_INT_BITS      4

// ==========================================================
// Gate driver current codes
`define BGS_DRV_MIN       2'h0
`define BGS_DRV_MED       2'h1
`define BGS_DRV_MAX       2'h2

// ==========================================================
// Short detection delays and retries
`define BGS_CLK_PERIOD_NS 10
`define BGS_DLY0_NS       3200
`define BGS_DLY1_NS       1600
`define BGS_DLY2_NS       1200
`define BGS_DLY3_NS       800
`define BGS_NS2CYC(ns)    (((ns) + `BGS_CLK_PERIOD_NS - 1) / `BGS_CLK_PERIOD_NS)
`define BGS_DLY_W         9
`define BGS_RETRY_MAX     2'h3

`endif

// File: logic/bgs_pkg.sv
// Types shared by the bridge guard modules
package bgs_pkg;

	// ==========================================================
	// Configuration as held in the control register
	typedef struct packed {
		logic [3:0] offTimeSetting;
		logic       lowSideDetectEnable;
		logic       protectionDisableBit;
		logic       highSideDetectSensitivity;
		logic [1:0] shortDelaySelect;
		logic [1:0] highSideSlope;
		logic [1:0] lowSideSlope;
	} bgs_cfg_s;

	// ==========================================================
	// Per-coil protection state
	typedef struct packed {
		logic bridgeOff;
		logic lowsideFault;
		logic highsideFault;
		logic retryPulse;
		logic faultPulse;
	} bgs_coil_s;

	typedef enum logic [1:0] {
		GRD_RUN,
		GRD_HOLD,
		GRD_LATCHED
	} bgs_guard_e;

endpackage : bgs_pkg

// File: logic/bgs_coil_guard.sv
// Short detection filter, retry and latch-off for one motor coil
`timescale 1ns/1ps
`include "bgs_defs.svh"

module bgs_coil_guard
	import bgs_pkg::*;
#(
	parameter int DLY_W = `BGS_DLY_W
)(
	input  wire logic             ref_clk,
	input  wire logic             resetn,
	input  wire logic             bridgeDisabled,
	input  wire logic             hsDetectOn,
	input  wire logic             lsDetectOn,
	input  wire logic [DLY_W-1:0] delayCycles,
	input  wire logic             hsShortRaw,
	input  wire logic             lsShortRaw,
	input  wire logic             chopperCycle,
	output bgs_coil_s             coilStat
);

	bgs_guard_e       state;
	logic [1:0]       retryCnt;
	logic [DLY_W-1:0] hsCnt;
	logic [DLY_W-1:0] lsCnt;
	logic             hsEvent;
	logic             lsEvent;
	logic             anyEvent;
	logic             cycleHadEvent;

	// Only a detector that stays tripped for the whole delay counts, so switching spikes pass
	assign hsEvent  = (state == GRD_RUN) && hsDetectOn && hsShortRaw && (hsCnt == delayCycles - 1'b1);
	assign lsEvent  = (state == GRD_RUN) && lsDetectOn && lsShortRaw && (lsCnt == delayCycles - 1'b1);
	assign anyEvent = hsEvent || lsEvent;

	// ==========================================================
	// Delay filters
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			hsCnt <= '0;
		else if (!hsShortRaw || !hsDetectOn || state != GRD_RUN || hsEvent)
			hsCnt <= '0;
		else
			hsCnt <= hsCnt + 1'b1;
	end

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			lsCnt <= '0;
		else if (!lsShortRaw || !lsDetectOn || state != GRD_RUN || lsEvent)
			lsCnt <= '0;
		else
			lsCnt <= lsCnt + 1'b1;
	end

	// ==========================================================
	// Retry sequencing
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			state         <= GRD_RUN;
			retryCnt      <= 2'h0;
			cycleHadEvent <= 1'b0;
		end
		else if (bridgeDisabled)
		begin
			state         <= GRD_RUN;
			retryCnt      <= 2'h0;
			cycleHadEvent <= 1'b0;
		end
		else
		begin
			case (state)
				GRD_RUN:
				begin
					if (anyEvent && retryCnt == `BGS_RETRY_MAX)
						state <= GRD_LATCHED;
					else if (anyEvent)
					begin
						state    <= GRD_HOLD;
						retryCnt <= retryCnt + 2'h1;
					end
					// A clean chopper cycle means the short did not persist
					if (chopperCycle && !anyEvent)
					begin
						if (!cycleHadEvent)
							retryCnt <= 2'h0;
						cycleHadEvent <= 1'b0;
					end
				end
				GRD_HOLD:
				begin
					cycleHadEvent <= 1'b1;
					if (chopperCycle)
						state <= GRD_RUN;
				end
				GRD_LATCHED:
					state <= GRD_LATCHED;
				default:
					state <= GRD_RUN;
			endcase
		end
	end

	// ==========================================================
	// Fault flags, cleared only while the bridge is disabled
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			coilStat.highsideFault <= 1'b0;
			coilStat.lowsideFault  <= 1'b0;
		end
		else if (bridgeDisabled)
		begin
			coilStat.highsideFault <= 1'b0;
			coilStat.lowsideFault  <= 1'b0;
		end
		else if (state == GRD_RUN && anyEvent && retryCnt == `BGS_RETRY_MAX)
		begin
			coilStat.highsideFault <= coilStat.highsideFault | hsEvent;
			coilStat.lowsideFault  <= coilStat.lowsideFault | lsEvent;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			coilStat.bridgeOff  <= 1'b0;
			coilStat.retryPulse <= 1'b0;
			coilStat.faultPulse <= 1'b0;
		end
		else
		begin
			coilStat.bridgeOff  <= !bridgeDisabled && (anyEvent || state == GRD_HOLD ||
				(state == GRD_LATCHED));
			coilStat.retryPulse <= !bridgeDisabled && anyEvent && retryCnt != `BGS_RETRY_MAX;
			coilStat.faultPulse <= !bridgeDisabled && anyEvent && retryCnt == `BGS_RETRY_MAX;
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	logic [DLY_W-1:0] hsRun;
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			hsRun <= '0;
		else if (!hsShortRaw)
			hsRun <= '0;
		else if (hsRun != '1)
			hsRun <= hsRun + 1'b1;
	end

	sequence s_final_event;
		state == GRD_RUN && anyEvent && retryCnt == `BGS_RETRY_MAX && !bridgeDisabled;
	endsequence

	a_retry_before_latch: assert property ($rose(state == GRD_LATCHED) |-> $past(retryCnt) == `BGS_RETRY_MAX)
		else $error("coil latched off before three retries");
	a_delay_filter: assert property (hsEvent |-> hsRun >= delayCycles - 1'b1)
		else $error("high-side short taken before its delay");
	a_latch_flags: assert property (s_final_event |=> coilStat.faultPulse && (coilStat.highsideFault ||
		coilStat.lowsideFault) ##1 state == GRD_LATCHED && coilStat.bridgeOff)
		else $error("confirmed short did not switch off the bridge");
	a_latch_holds: assert property (state == GRD_LATCHED && !bridgeDisabled |=> state == GRD_LATCHED)
		else $error("latched bridge released without disable");
	a_disable_clears: assert property (bridgeDisabled |=> retryCnt == 2'h0 && state == GRD_RUN &&
		!coilStat.highsideFault && !coilStat.lowsideFault)
		else $error("disable did not clear coil state");

endmodule : bgs_coil_guard

// File: logic/bgs_top.sv
// Gate slope, break-before-make, bridge disable and short protection with APB registers
`timescale 1ns/1ps
`include "bgs_defs.svh"

// Operation
// - Low-side slope: 0,1 min; 2 medium; 3 maximum
// - High-side slope: min, min+TC, med+TC, max
// - TC modes step up on temperature warning
// - Turn on only after opposite gate discharged
// - Disable input high switches all MOSFETs off
// - Off-time zero disables bridges like input
// - Retry three times, then latch bridge off
// - Detection delay 3.2, 1.6, 1.2, 0.8 us
// - Sensitivity flag selects high-side detector sensitivity
// - Protection-disable bit suppresses high-side detection
// - Low-side detection only when enable set
// - Per-coil short flag for persisting short
// - Disabling bridges clears every short flag
// - Separate low-side and high-side flags per coil
// - Confirmed short switches coil bridge off
// - Latched bridge stays off until disable cycle
module bgs_top
	import bgs_pkg::*;
#(
	parameter int HB_N  = 4,
	parameter int DLY_W = `BGS_DLY_W
)(
	input  wire logic                   ref_clk,
	input  wire logic                   resetn,
	input  wire logic [`BGS_ADDR_W-1:0] paddr,
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [31:0]            pwdata,
	input  wire logic [3:0]             pstrb,
	output logic [31:0]                 prdata,
	output logic                        pready,
	output logic                        pslverr,
	output logic                        irq,
	input  wire logic                   driverDisableIn,
	input  wire logic                   tempWarning,
	input  wire logic [HB_N-1:0]        phaseCmd,
	input  wire logic [HB_N-1:0]        hsGateSense,
	input  wire logic [HB_N-1:0]        lsGateSense,
	input  wire logic [1:0]             hsShortRaw,
	input  wire logic [1:0]             lsShortRaw,
	input  wire logic [1:0]             chopperCycle,
	output logic [HB_N-1:0]             hsGateEn,
	output logic [HB_N-1:0]             lsGateEn,
	output logic [1:0]                  lsDrive,
	output logic [1:0]                  hsDrive,
	output logic                        hsSenseHigh
);

	localparam logic [DLY_W-1:0] DLY0 = DLY_W'(`BGS_NS2CYC(`BGS_DLY0_NS));
	localparam logic [DLY_W-1:0] DLY1 = DLY_W'(`BGS_NS2CYC(`BGS_DLY1_NS));
	localparam logic [DLY_W-1:0] DLY2 = DLY_W'(`BGS_NS2CYC(`BGS_DLY2_NS));
	localparam logic [DLY_W-1:0] DLY3 = DLY_W'(`BGS_NS2CYC(`BGS_DLY3_NS));

	logic [31:0]              ctrlReg;
	bgs_cfg_s                 cfg;
	logic [`BGS_INT_BITS-1:0] intStat;
	logic [`BGS_INT_BITS-1:0] intMask;
	logic [`BGS_INT_BITS-1:0] intEvents;
	bgs_coil_s                coilStat [2];
	logic                     bridgeDisabled;
	logic                     hsDetectOn;
	logic                     lsDetectOn;
	logic [DLY_W-1:0]         delayCycles;
	logic [8:0]               statusWord;
	logic                     wrStrobe;
	logic                     rdStrobe;
	logic                     addrHit;
	logic [1:0]               next_hsDrive;
	logic [1:0]               next_lsDrive;

	assign cfg = bgs_cfg_s'(ctrlReg[`BGS_CTRL_BITS-1:0]);

	// ==========================================================
	// APB slave: one wait state, write strobe taken at the completing edge, read strobe one edge earlier in the wait state
	assign addrHit  = (paddr == `BGS_OFS_CTRL) || (paddr == `BGS_OFS_STATUS) ||
		(paddr == `BGS_OFS_INT_STAT) || (paddr == `BGS_OFS_INT_MASK);
	assign wrStrobe = psel && penable && pready && pwrite;
	assign rdStrobe = psel && penable && !pready && !pwrite;

	function automatic logic [31:0] bgs_merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++)
			if (strb[b])
				res[8*b +: 8] = wd[8*b +: 8];
		return res;
	endfunction : bgs_merge

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready  <= psel && penable && !pready;
			pslverr <= psel && penable && !pready && !addrHit;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			prdata <= 32'h0000_0000;
		else if (rdStrobe)
		begin
			case (paddr)
				`BGS_OFS_CTRL:     prdata <= ctrlReg;
				`BGS_OFS_STATUS:   prdata <= {23'h000000, statusWord};
				`BGS_OFS_INT_STAT: prdata <= {28'h0000000, intStat};
				`BGS_OFS_INT_MASK: prdata <= {28'h0000000, intMask};
				default:           prdata <= 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			ctrlReg <= `BGS_CTRL_RESET;
		else if (wrStrobe && paddr == `BGS_OFS_CTRL && !pslverr)
			ctrlReg <= bgs_merge(ctrlReg, pwdata, pstrb) & {19'h00000, {`BGS_CTRL_BITS{1'b1}}};
	end

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			intMask <= `BGS_MASK_RESET;
		else if (wrStrobe && paddr == `BGS_OFS_INT_MASK && pstrb[0])
			intMask <= pwdata[`BGS_INT_BITS-1:0];
	end

	// ==========================================================
	// Interrupts: sticky, write one to clear, a new event wins over the clear
	assign intEvents = {coilStat[1].retryPulse, coilStat[0].retryPulse,
		coilStat[1].faultPulse, coilStat[0].faultPulse};

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			intStat <= '0;
		else if (wrStrobe && paddr == `BGS_OFS_INT_STAT && pstrb[0])
			intStat <= (intStat & ~pwdata[`BGS_INT_BITS-1:0]) | intEvents;
		else
			intStat <= intStat | intEvents;
	end

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			irq <= 1'b0;
		else
			irq <= |(intStat & intMask);
	end

	// ==========================================================
	// Bridge enable and detector gating
	assign bridgeDisabled = driverDisableIn || (cfg.offTimeSetting == 4'h0);
	assign hsDetectOn     = !cfg.protectionDisableBit;
	assign lsDetectOn     = cfg.lowSideDetectEnable;

	always_comb
	begin
		case (cfg.shortDelaySelect)
			2'h0:    delayCycles = DLY0;
			2'h1:    delayCycles = DLY1;
			2'h2:    delayCycles = DLY2;
			default: delayCycles = DLY3;
		endcase
	end

	// Summary flag is the union of the detailed flags
	assign statusWord = {coilStat[1].bridgeOff, coilStat[0].bridgeOff, bridgeDisabled,
		coilStat[1].highsideFault, coilStat[0].highsideFault,
		coilStat[1].lowsideFault, coilStat[0].lowsideFault,
		coilStat[1].highsideFault | coilStat[1].lowsideFault,
		coilStat[0].highsideFault | coilStat[0].lowsideFault};

	// ==========================================================
	// Slope selection
	always_comb
	begin
		case (cfg.lowSideSlope)
			2'h2:    next_lsDrive = `BGS_DRV_MED;
			2'h3:    next_lsDrive = `BGS_DRV_MAX;
			default: next_lsDrive = `BGS_DRV_MIN;
		endcase
		case (cfg.highSideSlope)
			2'h1:    next_hsDrive = tempWarning ? `BGS_DRV_MED : `BGS_DRV_MIN;
			2'h2:    next_hsDrive = tempWarning ? `BGS_DRV_MAX : `BGS_DRV_MED;
			2'h3:    next_hsDrive = `BGS_DRV_MAX;
			default: next_hsDrive = `BGS_DRV_MIN;
		endcase
	end

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			lsDrive     <= `BGS_DRV_MIN;
			hsDrive     <= `BGS_DRV_MIN;
			hsSenseHigh <= 1'b0;
		end
		else
		begin
			lsDrive     <= next_lsDrive;
			hsDrive     <= next_hsDrive;
			hsSenseHigh <= cfg.highSideDetectSensitivity;
		end
	end

	// ==========================================================
	// Per-coil protection
	for (genvar c = 0; c < 2; c++)
	begin : g_coil
		bgs_coil_guard #(
			.DLY_W (DLY_W)
		) u_guard (
			.ref_clk        (ref_clk),
			.resetn         (resetn),
			.bridgeDisabled (bridgeDisabled),
			.hsDetectOn     (hsDetectOn),
			.lsDetectOn     (lsDetectOn),
			.delayCycles    (delayCycles),
			.hsShortRaw     (hsShortRaw[c]),
			.lsShortRaw     (lsShortRaw[c]),
			.chopperCycle   (chopperCycle[c]),
			.coilStat       (coilStat[c])
		);
	end

	// ==========================================================
	// Break-before-make per half-bridge; two half-bridges per coil
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	for (genvar h = 0; h < HB_N; h++)
	begin : g_half
		logic allowed;
		assign allowed = !bridgeDisabled && !coilStat[h / 2].bridgeOff;

		// Sensed gate charge is the only release, so slow slopes never cross-conduct
		always_ff @(posedge ref_clk or negedge resetn)
		begin
			if (!resetn)
			begin
				hsGateEn[h] <= 1'b0;
				lsGateEn[h] <= 1'b0;
			end
			else
			begin
				hsGateEn[h] <= allowed && phaseCmd[h] && !lsGateEn[h] && !lsGateSense[h];
				lsGateEn[h] <= allowed && !phaseCmd[h] && !hsGateEn[h] && !hsGateSense[h];
			end
		end

		a_overlap_high: assert property ($rose(hsGateEn[h]) |-> $past(!lsGateSense[h]) && !lsGateEn[h])
			else $error("high side turned on before low gate discharged");
		a_overlap_low: assert property ($rose(lsGateEn[h]) |-> $past(!hsGateSense[h]) && !hsGateEn[h])
			else $error("low side turned on before high gate discharged");
	end

	// ==========================================================
	// Checks
	sequence s_tc_warm;
		cfg.highSideSlope == 2'h1 && tempWarning;
	endsequence

	a_ls_slope: assert property ((cfg.lowSideSlope == 2'h2)[*2] |-> lsDrive == `BGS_DRV_MED)
		else $error("low-side slope code 2 not medium");
	a_hs_slope: assert property ((cfg.highSideSlope == 2'h0)[*2] |-> hsDrive == `BGS_DRV_MIN)
		else $error("high-side slope code 0 not minimum");
	a_tc_boost: assert property (s_tc_warm ##1 s_tc_warm |-> hsDrive == `BGS_DRV_MED)
		else $error("temperature compensation did not step up");
	a_pin_off: assert property (driverDisableIn |=> hsGateEn == '0 && lsGateEn == '0)
		else $error("gates on while disable input high");
	a_soft_off: assert property (cfg.offTimeSetting == 4'h0 |=> hsGateEn == '0 && lsGateEn == '0)
		else $error("gates on with off-time zero");
	a_sense_sel: assert property (cfg.highSideDetectSensitivity[*2] |-> hsSenseHigh)
		else $error("high sensitivity not applied");
	a_flags_clear: assert property (bridgeDisabled[*2] |-> statusWord[5:0] == 6'h00)
		else $error("short flags survive bridge disable");
	a_fault_off: assert property (coilStat[0].faultPulse |=> !hsGateEn[0] && !lsGateEn[0] &&
		!hsGateEn[1] && !lsGateEn[1])
		else $error("coil A bridge not off after fault");

endmodule : bgs_top

// File: dv/bgs_bridge_model.sv
// Behavioural half-bridges and motor coils seen by the bridge guard
`timescale 1ns/1ps

module bgs_bridge_model (
	input  wire logic       ref_clk,
	input  wire logic       slowSense,
	input  wire logic [3:0] hsGateEn,
	input  wire logic [3:0] lsGateEn,
	input  wire logic [1:0] hsFaultInj,
	input  wire logic [1:0] lsFaultInj,
	output logic      [3:0] hsGateSense,
	output logic      [3:0] lsGateSense,
	output logic      [1:0] hsShortRaw,
	output logic      [1:0] lsShortRaw
);
	logic [3:0] hsQ [3] = '{default: 4'h0};
	logic [3:0] lsQ [3] = '{default: 4'h0};
	logic [1:0] live;

	// ==========================================================
	// Gate discharge lags the command; slow mode mimics a weak driver
	always @(posedge ref_clk)
	begin
		hsQ <= '{hsGateEn, hsQ[0], hsQ[1]};
		lsQ <= '{lsGateEn, lsQ[0], lsQ[1]};
	end
	assign hsGateSense = hsGateEn | hsQ[0] | (slowSense ? (hsQ[1] | hsQ[2]) : 4'h0);
	assign lsGateSense = lsGateEn | lsQ[0] | (slowSense ? (lsQ[1] | lsQ[2]) : 4'h0);

	// ==========================================================
	// A short only shows while the coil's bridge conducts
	assign live       = {|(hsGateEn[3:2] | lsGateEn[3:2]), |(hsGateEn[1:0] | lsGateEn[1:0])};
	assign hsShortRaw = hsFaultInj & live;
	assign lsShortRaw = lsFaultInj & live;

endmodule : bgs_bridge_model

// File: dv/bgs_top_tb_top.sv
// Self-checking bench for the bridge guard
`timescale 1ns/1ps
`include "bgs_defs.svh"

module bgs_top_tb_top;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdq;
	logic [3:0]  phaseCmd, hsGateEn, lsGateEn, hsGateSense, lsGateSense, hsP, lsSP, lsP, hsSP;
	logic [1:0]  hsShortRaw, lsShortRaw, hsFaultInj, lsFaultInj, chopperCycle, lsDrive, hsDrive;
	logic        ref_clk, resetn, psel, penable, pwrite, pready, pslverr, irq, rerr;
	logic        driverDisableIn, tempWarning, hsSenseHigh, slowSense;
	int          num_errors = 0;
	int          n_compared = 0;
	int          dly [4] = '{320, 160, 120, 80};
	logic [31:0] base = 32'h0000_0300;

	always #5 ref_clk = ~ref_clk;

	bgs_top bgs_top_inst (.ref_clk(ref_clk), .resetn(resetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.irq(irq), .driverDisableIn(driverDisableIn), .tempWarning(tempWarning), .phaseCmd(phaseCmd),
		.hsGateSense(hsGateSense), .lsGateSense(lsGateSense), .hsShortRaw(hsShortRaw), .lsShortRaw(lsShortRaw),
		.chopperCycle(chopperCycle), .hsGateEn(hsGateEn), .lsGateEn(lsGateEn), .lsDrive(lsDrive),
		.hsDrive(hsDrive), .hsSenseHigh(hsSenseHigh));

	bgs_bridge_model bgs_bridge_model_inst (.ref_clk(ref_clk), .slowSense(slowSense), .hsGateEn(hsGateEn),
		.lsGateEn(lsGateEn), .hsFaultInj(hsFaultInj), .lsFaultInj(lsFaultInj), .hsGateSense(hsGateSense),
		.lsGateSense(lsGateSense), .hsShortRaw(hsShortRaw), .lsShortRaw(lsShortRaw));

	// ==========================================================
	// Checking and bus tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic end_of_test();
		if (num_errors == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : end_of_test

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : cyc

	// Idle cycle at the end keeps psel from being driven twice in one step
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int i;
		i = 0;
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do
		begin
			@(posedge ref_clk);
			i++;
		end
		while (pready !== 1'b1 && i < 20);
		rdq  = prdata;
		rerr = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1)
		begin
			num_errors++;
			end_of_test();
		end
		else
			@(posedge ref_clk);
	endtask : apb

	task automatic pulse(input logic [1:0] c);
		chopperCycle <= c;
		@(posedge ref_clk);
		chopperCycle <= 2'h0;
		cyc(3);
	endtask : pulse

	// Each trip: chopper pulse, then the detector stays tripped past the delay
	task automatic trips(input logic [1:0] c, input int n);
		for (int k = 0; k < n; k++)
		begin
			pulse(c);
			cyc(86);
			check(32'((hsGateEn | lsGateEn) & (c[0] ? 4'h3 : 4'hC)), 32'h0);
		end
	endtask : trips

	function automatic logic [1:0] drv(input logic [1:0] c, input logic tc);
		return (c == 2'h3) ? 2'h2 : (c == 2'h2) ? 2'h1 + 2'(tc) : 2'(tc & c[0]);
	endfunction : drv

	// ==========================================================
	// Cross-conduction monitor, judged on the values seen before each edge
	always @(posedge ref_clk)
	begin
		if (resetn && |((hsGateEn & lsGateEn) | (hsGateEn & ~hsP & lsSP) | (lsGateEn & ~lsP & hsSP)))
			check(32'h1, 32'h0);
		hsP  <= hsGateEn;
		lsP  <= lsGateEn;
		hsSP <= hsGateSense;
		lsSP <= lsGateSense;
	end

	// ==========================================================
	// Main sequence
	initial
	begin
		{ref_clk, resetn, psel, penable, pwrite, tempWarning, slowSense} = '0;
		driverDisableIn = 1'b0;
		{paddr, pwdata, phaseCmd, hsFaultInj, lsFaultInj, chopperCycle} = '0;
		{hsP, lsP, hsSP, lsSP} = '0;
		void'($urandom(32'h5A3B));
		cyc(2);
		resetn <= 1'b1;
		@(posedge ref_clk);
		check(32'({hsGateEn, lsGateEn}), 32'h0);
		apb(1'b0, `BGS_OFS_STATUS, 32'h0);
		check(rdq, 32'h40);
		apb(1'b0, 12'h010, 32'h0);
		check(32'(rerr), 32'h1);
		check(rdq, 32'h0);
		for (int i = 0; i < 32; i++)
		begin
			tempWarning <= i[4];
			apb(1'b1, `BGS_OFS_CTRL, 32'(i[3:0]) | (32'(i[4]) << 6));
			// Drive outputs are registered one edge after the control word lands
			cyc(1);
			check(32'(lsDrive), 32'(drv(i[1:0], 1'b0)));
			check(32'(hsDrive), 32'(drv(i[3:2], i[4])));
			check(32'(hsSenseHigh), 32'(i[4]));
		end
		tempWarning <= 1'b0;
		apb(1'b1, `BGS_OFS_CTRL, base | 32'h30);
		repeat (20)
		begin
			phaseCmd  <= 4'($urandom);
			slowSense <= 1'($urandom);
			cyc(10);
			check(32'({hsGateEn, lsGateEn}), 32'({phaseCmd, ~phaseCmd}));
		end
		slowSense <= 1'b0;
		driverDisableIn <= 1'b1;
		cyc(3);
		check(32'({hsGateEn, lsGateEn}), 32'h0);
		driverDisableIn <= 1'b0;
		apb(1'b1, `BGS_OFS_CTRL, 32'h30);
		cyc(1);
		check(32'({hsGateEn, lsGateEn}), 32'h0);
		for (int s = 0; s < 4; s++)
		begin
			apb(1'b1, `BGS_OFS_CTRL, base | 32'(s << 4));
			apb(1'b1, `BGS_OFS_INT_STAT, 32'hF);
			hsFaultInj <= 2'h1;
			cyc(dly[s] - 2);
			hsFaultInj <= 2'h0;
			apb(1'b0, `BGS_OFS_INT_STAT, 32'h0);
			check(rdq, 32'h0);
			hsFaultInj <= 2'h1;
			cyc(dly[s] + 6);
			hsFaultInj <= 2'h0;
			apb(1'b0, `BGS_OFS_INT_STAT, 32'h0);
			check(rdq, 32'h4);
			// End the hold, then two clean chopper cycles before the retry count clears
			pulse(2'h1);
			pulse(2'h1);
			pulse(2'h1);
		end
		apb(1'b1, `BGS_OFS_INT_STAT, 32'hF);
		apb(1'b1, `BGS_OFS_CTRL, base | 32'hB0);
		hsFaultInj <= 2'h1;
		apb(1'b1, `BGS_OFS_CTRL, 32'h2B0);
		lsFaultInj <= 2'h1;
		cyc(90);
		{hsFaultInj, lsFaultInj} <= '0;
		apb(1'b0, `BGS_OFS_INT_STAT, 32'h0);
		check(rdq, 32'h0);
		apb(1'b1, `BGS_OFS_CTRL, base | 32'h30);
		apb(1'b1, `BGS_OFS_INT_MASK, 32'h1);
		hsFaultInj <= 2'h1;
		trips(2'h1, 3);
		check(32'(irq), 32'h0);
		trips(2'h1, 1);
		apb(1'b0, `BGS_OFS_STATUS, 32'h0);
		check(rdq, 32'h91);
		check(32'(irq), 32'h1);
		trips(2'h1, 1);
		hsFaultInj <= 2'h0;
		apb(1'b1, `BGS_OFS_INT_STAT, 32'h1);
		cyc(2);
		check(32'(irq), 32'h0);
		apb(1'b0, `BGS_OFS_INT_STAT, 32'h0);
		check(rdq, 32'h4);
		driverDisableIn <= 1'b1;
		cyc(3);
		apb(1'b0, `BGS_OFS_STATUS, 32'h0);
		check(rdq & 32'h7F, 32'h40);
		driverDisableIn <= 1'b0;
		cyc(6);
		check(32'({hsGateEn, lsGateEn}), 32'({phaseCmd, ~phaseCmd}));
		hsFaultInj <= 2'h1;
		cyc(86);
		hsFaultInj <= 2'h0;
		apb(1'b0, `BGS_OFS_STATUS, 32'h0);
		check(rdq & 32'h3F, 32'h0);
		pulse(2'h1);
		pulse(2'h1);
		apb(1'b1, `BGS_OFS_INT_STAT, 32'hF);
		lsFaultInj <= 2'h2;
		trips(2'h2, 4);
		lsFaultInj <= 2'h0;
		apb(1'b0, `BGS_OFS_STATUS, 32'h0);
		check(rdq, 32'h10A);
		apb(1'b0, `BGS_OFS_INT_STAT, 32'h0);
		check(rdq, 32'hA);
		end_of_test();
	end

endmodule : bgs_top_tb_top
